// *** rtl/output_smoother.sv ***
// First-order output filter for one measured quantity.
`timescale 1ns/1ps
`default_nettype none
module output_smoother (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic load,
  input wire logic [16:0] factor,
  input wire logic [15:0] sample,
  output logic [15:0] value_q
);
  logic [15:0] value_d;
  logic [32:0] acc;

  always_comb begin
    acc = 33'(factor) * 33'(sample)
        + 33'(purge_filter_pkg::FILTER_ONE - factor) * 33'(value_q);
    value_d = value_q;
    if (load) begin
      value_d = acc[31:16];
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      value_q <= 16'h0000;
    end else begin
      value_q <= value_d;
    end
  end

  property p_pass_through;
    @(posedge clock) disable iff (!reset_n)
    load && factor == purge_filter_pkg::FILTER_ONE |=> value_q == $past(sample);
  endproperty
  a_pass_through: assert property (p_pass_through)
    else $error("Factor one did not pass the sample through.");
endmodule : output_smoother
`default_nettype wire

// *** rtl/purge_filter_pkg.sv ***
// Constants shared by the purge scheduler and its output filters.
package purge_filter_pkg;
  localparam int CLOCK_HZ = 200_000_000;
  localparam int TICK_TIME_S = 1;
  localparam int TICK_CYCLES = CLOCK_HZ * TICK_TIME_S;

  localparam int PURGE_TIME_MIN = 4;
  localparam logic [19:0] PURGE_SECONDS = 20'(PURGE_TIME_MIN * 60);
  localparam int DEFER_TIME_MIN = 30;
  localparam logic [19:0] DEFER_SECONDS = 20'(DEFER_TIME_MIN * 60);
  localparam logic [19:0] SECONDS_PER_HOUR = 20'h00e10;
  localparam logic [7:0] INTERVAL_DEFAULT_H = 8'h18;
  localparam logic [7:0] INTERVAL_MIN_H = 8'h01;
  localparam logic [7:0] INTERVAL_MAX_H = 8'ha8;

  localparam logic [15:0] FILTER_FACTOR_ADDR = 16'h0308;
  localparam logic [16:0] FILTER_ONE = 17'h10000;
  localparam logic [31:0] FILTER_FACTOR_RESET = 32'(FILTER_ONE);

  localparam logic [15:0] PEROXIDE_MAX_PPM = 16'h07d0;
  localparam logic [23:0] FIXED_PRESSURE_CHPA = 24'h018bcd;

  typedef enum {st_idle, st_purge} purge_state_t;
endpackage : purge_filter_pkg

// *** rtl/purge_scheduler.sv ***
// Purge scheduling, measurement blanking, pressure value and filtering.
//
// How it works
// - A purge heats the sensors for 240 one-second ticks, 239 to 240 seconds.
// - Both concentration outputs are flagged unavailable throughout a purge.
// - A purge starts after power-up and after a humidity adjustment.
// - Periodic purges every 1 to 168 hours, default 24 hours.
// - A due periodic purge waits 30 minutes when vapour or humidity unsteady.
// - A configuration bit lets periodic purges proceed despite vapour.
// - A purge request by register write in digital mode, or by connector pin otherwise, starts a purge.
// - Compensation off after reset; then 1013.25 hPa is used.
// - With compensation on, the externally written setpoint is used.
// - Filter factor resets to 1.0, passing measurements straight through.
// - Output is factor times new sample plus remainder times old output.
// - Filter factor is read and written at holding register 0x0308.
// - Reported peroxide concentration spans 0 to 2000 ppm.
`timescale 1ns/1ps
`default_nettype none
module purge_scheduler #(
  parameter int TICK_CYCLES = purge_filter_pkg::TICK_CYCLES
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [15:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata_q,
  output logic reg_rvalid_q,
  input wire logic digital_mode,
  input wire logic purge_write_req,
  input wire logic purge_pin,
  input wire logic adjust_done,
  input wire logic [7:0] interval_hours,
  input wire logic purge_in_exposure,
  input wire logic peroxide_present,
  input wire logic humidity_unsteady,
  input wire logic comp_enable,
  input wire logic [23:0] pressure_setpoint,
  input wire logic meas_valid,
  input wire logic [15:0] meas_peroxide,
  input wire logic [15:0] meas_water,
  output logic heater_on_q,
  output logic peroxide_unavail_q,
  output logic water_unavail_q,
  output logic [15:0] peroxide_out_q,
  output logic [15:0] water_out_q,
  output logic [23:0] comp_pressure_q
);
  purge_filter_pkg::purge_state_t state_q, state_d;
  logic [31:0] tick_cnt_q, tick_cnt_d;
  logic sec_tick_q, sec_tick_d;
  logic [19:0] purge_secs_q, purge_secs_d;
  logic [19:0] elapsed_q, elapsed_d;
  logic [19:0] defer_q, defer_d;
  logic start_pending_q, start_pending_d;
  logic pin_q;
  logic [31:0] factor_q, factor_d;
  logic [31:0] rdata_d;
  logic [23:0] pressure_d;
  logic [7:0] hours;
  logic [19:0] interval_secs;
  logic due, blocked, periodic_go, request, start, active;
  logic [15:0] peroxide_clamped;

  // One-second enable; everything slower counts these pulses.
  always_comb begin
    tick_cnt_d = tick_cnt_q + 32'h0000_0001;
    sec_tick_d = 1'b0;
    if (tick_cnt_q == 32'(TICK_CYCLES - 1)) begin
      tick_cnt_d = 32'h0000_0000;
      sec_tick_d = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      tick_cnt_q <= 32'h0000_0000;
      sec_tick_q <= 1'b0;
    end else begin
      tick_cnt_q <= tick_cnt_d;
      sec_tick_q <= sec_tick_d;
    end
  end

  // An out-of-range interval is clamped rather than rejected; zero means
  // the default interval.
  always_comb begin
    hours = interval_hours;
    if (interval_hours == 8'h00) begin
      hours = purge_filter_pkg::INTERVAL_DEFAULT_H;
    end else if (interval_hours > purge_filter_pkg::INTERVAL_MAX_H) begin
      hours = purge_filter_pkg::INTERVAL_MAX_H;
    end else if (interval_hours < purge_filter_pkg::INTERVAL_MIN_H) begin
      hours = purge_filter_pkg::INTERVAL_MIN_H;
    end
    interval_secs = 20'(hours) * purge_filter_pkg::SECONDS_PER_HOUR;
  end

  assign active = (state_q == purge_filter_pkg::st_purge);
  assign due = (elapsed_q >= interval_secs);
  assign blocked = (peroxide_present && !purge_in_exposure)
                 || humidity_unsteady;
  assign periodic_go = due && (defer_q == 20'h00000) && !blocked;
  assign request = digital_mode ? purge_write_req
                                : (purge_pin && !pin_q);
  assign start = !active
               && (start_pending_q || adjust_done || request || periodic_go);

  always_comb begin
    state_d = state_q;
    purge_secs_d = purge_secs_q;
    elapsed_d = elapsed_q;
    defer_d = defer_q;
    start_pending_d = start_pending_q;
    case (state_q)
      purge_filter_pkg::st_idle: begin
        if (start) begin
          state_d = purge_filter_pkg::st_purge;
          start_pending_d = 1'b0;
          purge_secs_d = 20'h00000;
          defer_d = 20'h00000;
        end else begin
          if (due && defer_q == 20'h00000 && blocked) begin
            defer_d = purge_filter_pkg::DEFER_SECONDS;
          end else if (sec_tick_q && defer_q != 20'h00000) begin
            defer_d = defer_q - 20'h00001;
          end
          if (sec_tick_q && !due) begin
            elapsed_d = elapsed_q + 20'h00001;
          end
        end
      end
      purge_filter_pkg::st_purge: begin
        if (sec_tick_q) begin
          purge_secs_d = purge_secs_q + 20'h00001;
          if (purge_secs_q == purge_filter_pkg::PURGE_SECONDS - 20'h00001)
          begin
            state_d = purge_filter_pkg::st_idle;
            elapsed_d = 20'h00000;
          end
        end
      end
      default: begin
        state_d = purge_filter_pkg::st_idle;
      end
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= purge_filter_pkg::st_idle;
      purge_secs_q <= 20'h00000;
      elapsed_q <= 20'h00000;
      defer_q <= 20'h00000;
      start_pending_q <= 1'b1;
      pin_q <= 1'b0;
      heater_on_q <= 1'b0;
      peroxide_unavail_q <= 1'b0;
      water_unavail_q <= 1'b0;
    end else begin
      state_q <= state_d;
      purge_secs_q <= purge_secs_d;
      elapsed_q <= elapsed_d;
      defer_q <= defer_d;
      start_pending_q <= start_pending_d;
      pin_q <= purge_pin;
      heater_on_q <= (state_d == purge_filter_pkg::st_purge);
      peroxide_unavail_q <= (state_d == purge_filter_pkg::st_purge);
      water_unavail_q <= (state_d == purge_filter_pkg::st_purge);
    end
  end

  // Register port and pressure selection. A factor above one is stored as
  // one, so the filter can never amplify.
  always_comb begin
    factor_d = factor_q;
    if (reg_wr_en && reg_addr == purge_filter_pkg::FILTER_FACTOR_ADDR) begin
      factor_d = reg_wdata;
      if (reg_wdata > purge_filter_pkg::FILTER_FACTOR_RESET) begin
        factor_d = purge_filter_pkg::FILTER_FACTOR_RESET;
      end
    end
    rdata_d = 32'h0000_0000;
    if (reg_addr == purge_filter_pkg::FILTER_FACTOR_ADDR) begin
      rdata_d = factor_q;
    end
    pressure_d = purge_filter_pkg::FIXED_PRESSURE_CHPA;
    if (comp_enable) begin
      pressure_d = pressure_setpoint;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      factor_q <= purge_filter_pkg::FILTER_FACTOR_RESET;
      reg_rdata_q <= 32'h0000_0000;
      reg_rvalid_q <= 1'b0;
      comp_pressure_q <= purge_filter_pkg::FIXED_PRESSURE_CHPA;
    end else begin
      factor_q <= factor_d;
      reg_rdata_q <= reg_rd_en ? rdata_d : reg_rdata_q;
      reg_rvalid_q <= reg_rd_en;
      comp_pressure_q <= pressure_d;
    end
  end

  assign peroxide_clamped = (meas_peroxide > purge_filter_pkg::PEROXIDE_MAX_PPM)
                          ? purge_filter_pkg::PEROXIDE_MAX_PPM
                          : meas_peroxide;

  // Filters freeze during a purge so stale outputs are held, not smeared.
  output_smoother peroxide_filter (
    .clock(clock),
    .reset_n(reset_n),
    .load(meas_valid && !active),
    .factor(factor_q[16:0]),
    .sample(peroxide_clamped),
    .value_q(peroxide_out_q)
  );

  output_smoother water_filter (
    .clock(clock),
    .reset_n(reset_n),
    .load(meas_valid && !active),
    .factor(factor_q[16:0]),
    .sample(meas_water),
    .value_q(water_out_q)
  );

  property p_purge_length;
    @(posedge clock) disable iff (!reset_n)
    $fell(active) |-> $past(purge_secs_q) == purge_filter_pkg::PURGE_SECONDS
                      - 20'h00001 && elapsed_q == 20'h00000;
  endproperty
  a_purge_length: assert property (p_purge_length)
    else $error("Purge ended at the wrong time.");

  // Flags are checked while the purge state holds; a check one cycle later
  // would trip on the last purge cycle, when the flags drop with the state.
  property p_blank;
    @(posedge clock) disable iff (!reset_n)
    active |-> (peroxide_unavail_q && water_unavail_q)
               ##1 ($stable(peroxide_out_q) && $stable(water_out_q));
  endproperty
  a_blank: assert property (p_blank)
    else $error("Outputs not blanked during purge.");

  property p_startup;
    @(posedge clock) disable iff (!reset_n)
    start_pending_q && !active |=> active ##1 heater_on_q;
  endproperty
  a_startup: assert property (p_startup)
    else $error("No purge after power-up.");

  property p_adjust;
    @(posedge clock) disable iff (!reset_n)
    adjust_done && !active |=> active;
  endproperty
  a_adjust: assert property (p_adjust)
    else $error("No purge after adjustment.");

  property p_defer;
    @(posedge clock) disable iff (!reset_n)
    !active && !start && due && defer_q == 20'h00000 && blocked
      |=> defer_q == purge_filter_pkg::DEFER_SECONDS && !active;
  endproperty
  a_defer: assert property (p_defer)
    else $error("Blocked periodic purge not deferred.");

  property p_bypass;
    @(posedge clock) disable iff (!reset_n)
    !active && due && defer_q == 20'h00000 && purge_in_exposure
      && peroxide_present && !humidity_unsteady |=> active;
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("Exposure bypass did not start purge.");

  property p_request;
    @(posedge clock) disable iff (!reset_n)
    !active && digital_mode && purge_write_req |=> active;
  endproperty
  a_request: assert property (p_request)
    else $error("Purge request ignored.");

  property p_fixed_pressure;
    @(posedge clock) disable iff (!reset_n)
    !comp_enable ##1 !comp_enable
      |-> comp_pressure_q == purge_filter_pkg::FIXED_PRESSURE_CHPA;
  endproperty
  a_fixed_pressure: assert property (p_fixed_pressure)
    else $error("Fixed pressure not used.");

  property p_setpoint;
    @(posedge clock) disable iff (!reset_n)
    comp_enable |=> comp_pressure_q == $past(pressure_setpoint);
  endproperty
  a_setpoint: assert property (p_setpoint)
    else $error("Pressure setpoint not applied.");

  property p_range;
    @(posedge clock) disable iff (!reset_n)
    1'b1 |-> peroxide_out_q <= purge_filter_pkg::PEROXIDE_MAX_PPM;
  endproperty
  a_range: assert property (p_range)
    else $error("Peroxide output above range.");

  property p_readback;
    @(posedge clock) disable iff (!reset_n)
    reg_rd_en && reg_addr == purge_filter_pkg::FILTER_FACTOR_ADDR
      |=> reg_rvalid_q && reg_rdata_q == $past(factor_q);
  endproperty
  a_readback: assert property (p_readback)
    else $error("Filter factor readback wrong.");
endmodule : purge_scheduler
`default_nettype wire

// *** verification/modbus_master_model.sv ***
// Register-bus master model standing in for the serial-line master.
`timescale 1ns/1ps
`default_nettype none
module modbus_master_model (
  input wire logic clock,
  input wire logic [31:0] reg_rdata_q,
  input wire logic reg_rvalid_q,
  output logic reg_wr_en,
  output logic reg_rd_en,
  output logic [15:0] reg_addr,
  output logic [31:0] reg_wdata,
  output logic purge_write_req,
  output logic comp_enable,
  output logic [23:0] pressure_setpoint
);
  initial begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = 16'h0000;
    reg_wdata = 32'h00000000;
    purge_write_req = 1'b0;
    comp_enable = 1'b0;
    pressure_setpoint = 24'h000000;
  end

  // Idle address and data are inverted so a stale value never looks valid.
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(negedge clock);
    reg_wr_en = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : wr

  task automatic rd(input logic [15:0] a, output logic [31:0] d);
    d = 'x;
    @(negedge clock);
    reg_addr = a;
    reg_rd_en = 1'b1;
    for (int i = 0; i < 4; i++) begin
      @(negedge clock);
      reg_rd_en = 1'b0;
      reg_addr = ~a;
      if (reg_rvalid_q === 1'b1) begin
        d = reg_rdata_q;
        break;
      end
    end
  endtask : rd

  task automatic request_purge();
    @(negedge clock);
    purge_write_req = 1'b1;
    @(negedge clock);
    purge_write_req = 1'b0;
  endtask : request_purge

  // The device has no barometer, so the master supplies the pressure.
  task automatic set_pressure(input logic en, input logic [23:0] p);
    @(negedge clock);
    pressure_setpoint = p;
    comp_enable = en;
  endtask : set_pressure
endmodule : modbus_master_model
`default_nettype wire

// *** verification/tb_purge_scheduler.sv ***
// Self-checking testbench for the purge scheduler.
`timescale 1ns/1ps
`default_nettype none
module tb_purge_scheduler;
  // A short tick keeps hour-long intervals within a practical run.
  localparam int TICK = 4;
  localparam int HOUR = 3600 * TICK;
  localparam int DEFER = 1800 * TICK;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic digital_mode = 1'b1, purge_pin = 1'b0, adjust_done = 1'b0;
  logic [7:0] interval_hours = 8'h00;
  logic purge_in_exposure = 1'b0, peroxide_present = 1'b0;
  logic humidity_unsteady = 1'b0, meas_valid = 1'b0;
  logic [15:0] meas_peroxide = 16'h0000, meas_water = 16'h0000;
  logic reg_wr_en, reg_rd_en, reg_rvalid_q, purge_write_req, comp_enable;
  logic [15:0] reg_addr, peroxide_out_q, water_out_q;
  logic [31:0] reg_wdata, reg_rdata_q, rdata;
  logic [23:0] pressure_setpoint, comp_pressure_q;
  logic heater_on_q, peroxide_unavail_q, water_unavail_q;
  int bad_count = 0;
  int comparisons = 0;

  always #2.5 clock = ~clock;

  purge_scheduler #(.TICK_CYCLES(TICK)) dut (.clock(clock),
    .reset_n(reset_n), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
    .reg_rvalid_q(reg_rvalid_q), .digital_mode(digital_mode),
    .purge_write_req(purge_write_req), .purge_pin(purge_pin),
    .adjust_done(adjust_done), .interval_hours(interval_hours),
    .purge_in_exposure(purge_in_exposure),
    .peroxide_present(peroxide_present),
    .humidity_unsteady(humidity_unsteady), .comp_enable(comp_enable),
    .pressure_setpoint(pressure_setpoint), .meas_valid(meas_valid),
    .meas_peroxide(meas_peroxide), .meas_water(meas_water),
    .heater_on_q(heater_on_q), .peroxide_unavail_q(peroxide_unavail_q),
    .water_unavail_q(water_unavail_q), .peroxide_out_q(peroxide_out_q),
    .water_out_q(water_out_q), .comp_pressure_q(comp_pressure_q));

  modbus_master_model mb (.clock(clock), .reg_rdata_q(reg_rdata_q),
    .reg_rvalid_q(reg_rvalid_q), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .purge_write_req(purge_write_req), .comp_enable(comp_enable),
    .pressure_setpoint(pressure_setpoint));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic in_range(input int n, input int lo, input int hi);
    check(32'(n >= lo && n <= hi), 32'h00000001);
  endtask : in_range

  task automatic wait_heater(input logic lvl, input int lim, output int n);
    n = 0;
    while (heater_on_q !== lvl && n < lim) begin
      @(negedge clock);
      n++;
    end
  endtask : wait_heater

  // Checks blanking and length of a purge whose heater is already on.
  task automatic purge_tail();
    int n;
    check({peroxide_unavail_q, water_unavail_q}, 32'h3);
    wait_heater(1'b0, 241 * TICK, n);
    in_range(n, 239 * TICK - 4, 240 * TICK + 2);
    check({peroxide_unavail_q, water_unavail_q}, 32'h0);
  endtask : purge_tail

  task automatic sample(input logic [15:0] p, input logic [15:0] w);
    @(negedge clock);
    meas_peroxide = p;
    meas_water = w;
    meas_valid = 1'b1;
    @(negedge clock);
    meas_valid = 1'b0;
  endtask : sample

  task automatic test_startup();
    int n;
    check(comp_pressure_q, 32'h00018bcd);
    mb.rd(16'h0308, rdata);
    check(rdata, 32'h00010000);
    check(reg_rvalid_q, 32'h00000001);
    @(negedge clock);
    check(reg_rvalid_q, 32'h00000000);
    wait_heater(1'b1, 4, n);
    check(heater_on_q, 1'b1);
    purge_tail();
    $display("test_startup done");
  endtask : test_startup

  task automatic test_filter();
    sample(16'h0bb8, 16'h04d2);
    check(peroxide_out_q, 32'h07d0);
    check(water_out_q, 32'h04d2);
    mb.wr(16'h0308, 32'h00008000);
    mb.rd(16'h0308, rdata);
    check(rdata, 32'h00008000);
    sample(16'h03e8, 16'h0000);
    check(peroxide_out_q, 32'h05dc);
    check(water_out_q, 32'h0269);
    mb.wr(16'h0309, 32'h00001234);
    mb.rd(16'h0309, rdata);
    check(rdata, 32'h00000000);
    mb.wr(16'h0308, 32'h00020000);
    mb.rd(16'h0308, rdata);
    check(rdata, 32'h00010000);
    $display("test_filter done");
  endtask : test_filter

  // Adjustment, register request and connector pin each start a purge.
  task automatic test_requests();
    int n;
    for (int c = 0; c < 3; c++) begin
      @(negedge clock);
      digital_mode = (c != 2);
      if (c == 0) adjust_done = 1'b1;
      if (c == 1) mb.request_purge();
      if (c == 2) purge_pin = 1'b1;
      @(negedge clock);
      adjust_done = 1'b0;
      wait_heater(1'b1, 6, n);
      check(heater_on_q, 1'b1);
      sample(16'h0064, 16'h0064);
      check(peroxide_out_q, 32'h000005dc);
      check(water_out_q, 32'h00000269);
      purge_tail();
      purge_pin = 1'b0;
    end
    $display("test_requests done");
  endtask : test_requests

  task automatic test_comp();
    mb.set_pressure(1'b1, 24'h0186a0);
    repeat (3) @(negedge clock);
    check(comp_pressure_q, 32'h000186a0);
    mb.set_pressure(1'b0, 24'h0186a0);
    repeat (3) @(negedge clock);
    check(comp_pressure_q, 32'h00018bcd);
    $display("test_comp done");
  endtask : test_comp

  // One-hour interval; vapour defers, exposure lets vapour through, humidity defers.
  task automatic test_periodic();
    int n, m;
    logic [3:0] cases [3] = '{4'b1001, 4'b1100, 4'b0111};
    interval_hours = 8'h01;
    adjust_done = 1'b1;
    @(negedge clock);
    adjust_done = 1'b0;
    wait_heater(1'b1, 6, n);
    purge_tail();
    foreach (cases[i]) begin
      {peroxide_present, purge_in_exposure, humidity_unsteady} = cases[i][3:1];
      wait_heater(1'b1, HOUR + 100, n);
      peroxide_present = 1'b0;
      humidity_unsteady = 1'b0;
      wait_heater(1'b1, DEFER, m);
      in_range(n + m, HOUR + DEFER * cases[i][0] - 12,
               HOUR + DEFER * cases[i][0] + 12);
      purge_tail();
    end
    $display("test_periodic done");
  endtask : test_periodic

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : complete_run

  initial begin
    repeat (10) @(negedge clock);
    reset_n = 1'b1;
    test_startup();
    test_filter();
    test_requests();
    test_comp();
    test_periodic();
    complete_run();
  end

  initial begin
    repeat (95000) @(posedge clock);
    bad_count++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    complete_run();
  end
endmodule : tb_purge_scheduler
`default_nettype wire
